// ===== core/l2es_pkg.sv
// Constants, types and helper functions shared by the L2 event selector.
package l2es_pkg;

    // ------------------------------------------------------------
    // Event numbers
    // ------------------------------------------------------------
    localparam logic [7:0] L2ES_L2_DATA_REQUEST_EVENT = 8'h26;
    localparam logic [7:0] L2ES_L2_OWNERSHIP_WRITE_EVENT = 8'h27;
    localparam logic [7:0] L2ES_L1_WRITEBACK_EVENT = 8'h28;

    // ------------------------------------------------------------
    // Unit mask layout: low nibble and high nibble of state bits
    // ------------------------------------------------------------
    localparam int L2ES_NIB_W = 4;
    localparam int L2ES_LO_NIB_LSB = 0;
    localparam int L2ES_HI_NIB_LSB = 4;

    // ------------------------------------------------------------
    // Line states and request classes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        L2ES_ST_I,
        L2ES_ST_S,
        L2ES_ST_E,
        L2ES_ST_M
    } l2es_mesi_e;

    typedef enum logic [1:0] {
        L2ES_CL_LOAD,
        L2ES_CL_STORE_RFO,
        L2ES_CL_LOCK_RFO,
        L2ES_CL_WRITEBACK
    } l2es_class_e;

    // ------------------------------------------------------------
    // Register bus layout (byte addresses)
    // ------------------------------------------------------------
    localparam int L2ES_ADDR_W = 4;
    localparam int L2ES_DATA_W = 32;
    localparam int L2ES_BE_W = 4;
    localparam logic [3:0] L2ES_OFS_CTRL = 4'h0;
    localparam logic [3:0] L2ES_OFS_STATUS = 4'h4;
    localparam logic [3:0] L2ES_OFS_LAST = 4'h8;

    // Control fields
    localparam int L2ES_CTRL_EVT_LSB = 0;
    localparam int L2ES_CTRL_MASK_LSB = 8;
    localparam int L2ES_CTRL_EN_BIT = 16;
    localparam logic [7:0] L2ES_EVT_RST = 8'h00;
    localparam logic [7:0] L2ES_MASK_RST = 8'h00;

    // Status fields (write one to clear)
    localparam int L2ES_STAT_SEEN_BIT = 0;
    localparam int L2ES_STAT_MISS_BIT = 1;

    // Last-match fields
    localparam int L2ES_LAST_STATE_LSB = 0;
    localparam int L2ES_LAST_CLASS_LSB = 2;
    localparam int L2ES_LAST_MISS_BIT = 4;
    localparam int L2ES_LAST_PF_BIT = 5;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // One-hot state select, bit order I, S, E, M
    function automatic logic [3:0] l2es_state_onehot(input l2es_mesi_e st);
        l2es_state_onehot = 4'h1 << st;
    endfunction : l2es_state_onehot

    // Pick one nibble of the unit mask
    function automatic logic [3:0] l2es_nibble(input logic [7:0] m, input logic hi);
        l2es_nibble = hi ? m[L2ES_HI_NIB_LSB +: L2ES_NIB_W] : m[L2ES_LO_NIB_LSB +: L2ES_NIB_W];
    endfunction : l2es_nibble

endpackage : l2es_pkg

// ===== core/l2es_req_if.sv
// Staged cache request carried from the top to the qualifier.
`timescale 1ns/1ps
interface l2es_req_if;
    import l2es_pkg::*;
    logic valid;
    l2es_class_e cls;
    l2es_mesi_e state;
    logic l2_pf;
    logic own;

    modport src (output valid, output cls, output state, output l2_pf, output own);
    modport dst (input valid, input cls, input state, input l2_pf, input own);
endinterface : l2es_req_if

// ===== core/l2es_match.sv
// Combinational event and unit mask qualifier for one staged request.
`timescale 1ns/1ps
module l2es_match
    import l2es_pkg::*;
(
    // Staged request
    l2es_req_if.dst req,
    // Selection
    input wire logic [7:0] event_i,
    input wire logic [7:0] umask_i,
    // Result
    output logic match_o,
    output logic miss_o
);
    logic [3:0] oh;
    logic [3:0] sel;

    // Choose the nibble of state bits that applies to this request
    always_comb begin
        oh = l2es_state_onehot(req.state);
        sel = 4'h0;
        case (event_i)
            L2ES_L2_DATA_REQUEST_EVENT: begin
                // L1D misses and L1D prefetches are both demand
                if (req.cls == L2ES_CL_LOAD) begin
                    sel = l2es_nibble(umask_i, req.l2_pf);
                end
            end
            L2ES_L2_OWNERSHIP_WRITE_EVENT: begin
                // Stores never count as prefetches here
                if (req.cls == L2ES_CL_STORE_RFO) begin
                    sel = l2es_nibble(umask_i, 1'b0);
                end else if (req.cls == L2ES_CL_LOCK_RFO) begin
                    sel = l2es_nibble(umask_i, 1'b1);
                end
            end
            L2ES_L1_WRITEBACK_EVENT: begin
                if (req.cls == L2ES_CL_WRITEBACK) begin
                    sel = l2es_nibble(umask_i, 1'b0);
                end
            end
            default: begin
                sel = 4'h0;
            end
        endcase
        // Any selected state bit qualifies, so full masks count all
        match_o = req.valid && ((sel & oh) != 4'h0);
        // Ownership prefetch on a shared line needs the line upgraded
        miss_o = (req.state == L2ES_ST_I) ||
                 (req.l2_pf && req.own && req.state == L2ES_ST_S);
    end
endmodule : l2es_match

// ===== core/l2es_pulse.sv
// Registers the qualified match into a one-cycle count pulse.
`timescale 1ns/1ps
module l2es_pulse
    import l2es_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Qualified match
    input wire logic enable_i,
    input wire logic match_i,
    input wire logic miss_i,
    // Toward the counter
    output logic pulse_o,
    output logic miss_o
);
    logic pulse_q;
    logic pulse_d;
    logic miss_q;
    logic miss_d;

    // Next values: one pulse per qualifying request
    always_comb begin
        pulse_d = enable_i && match_i;
        miss_d = enable_i && match_i && miss_i;
    end

    // Output registers
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pulse_q <= 1'b0;
            miss_q <= 1'b0;
        end else begin
            pulse_q <= pulse_d;
            miss_q <= miss_d;
        end
    end

    assign pulse_o = pulse_q;
    assign miss_o = miss_q;
endmodule : l2es_pulse

// ===== core/l2es_top.sv
// Top of the L2 cache event selector: bus slave, request stage, status.
// Contract
// - Data event low nibble counts demand loads by line state I, S, E, M.
// - Data demand class covers L1D demand misses and L1D prefetches.
// - All four demand bits set counts every demand data request.
// - Data event high nibble counts prefetch loads by line state I, S, E, M.
// - Prefetch ownership on shared line is a miss; prefetch read there hits.
// - Mask F0H under data event counts every prefetch data request.
// - Mask FFH under data event counts every data request.
// - Write event low nibble counts store ownership by I, S, E, M state.
// - Write event mask 0EH counts store ownership hits in S, E, M.
// - Write event low nibble all set counts every store ownership request.
// - Every counted store ownership request is treated as demand.
// - Write event high nibble counts lock ownership by I, S, E, M state.
// - Lock S, E and M bits together count lock ownership hits.
// - Mask F0H under write event counts every lock ownership request.
// - Writeback event low nibble counts L1 writebacks by line state.
// - Mask 0FH under writeback event counts every L1 writeback.
//
// Implementation choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
module l2es_top
    import l2es_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Avalon-MM slave
    input wire logic [L2ES_ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [L2ES_DATA_W-1:0] avs_writedata_i,
    input wire logic [L2ES_BE_W-1:0] avs_byteenable_i,
    output logic [L2ES_DATA_W-1:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Request from the L2 pipeline, same clock
    input wire logic req_valid_i,
    input wire logic [1:0] req_class_i,
    input wire logic [1:0] req_state_i,
    input wire logic req_l2_prefetch_i,
    input wire logic req_ownership_i,
    // Toward the performance counter
    output logic count_pulse_o,
    output logic count_miss_o
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    l2es_req_if stage_if ();

    logic ack_q;
    logic ack_d;
    logic [L2ES_DATA_W-1:0] rdata_q;
    logic [L2ES_DATA_W-1:0] rdata_d;

    logic [7:0] evt_q;
    logic [7:0] evt_d;
    logic [7:0] mask_q;
    logic [7:0] mask_d;
    logic en_q;
    logic en_d;

    logic seen_q;
    logic seen_d;
    logic miss_seen_q;
    logic miss_seen_d;

    logic [1:0] last_state_q;
    logic [1:0] last_state_d;
    logic [1:0] last_class_q;
    logic [1:0] last_class_d;
    logic last_miss_q;
    logic last_miss_d;
    logic last_pf_q;
    logic last_pf_d;

    logic stg_valid_q;
    logic stg_valid_d;
    l2es_class_e stg_cls_q;
    l2es_class_e stg_cls_d;
    l2es_mesi_e stg_state_q;
    l2es_mesi_e stg_state_d;
    logic stg_pf_q;
    logic stg_pf_d;
    logic stg_own_q;
    logic stg_own_d;

    logic bus_req;
    logic wr_take;
    logic rd_take;
    logic match;
    logic miss;
    logic hit_event;

    // ------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------
    // One wait cycle per access keeps read data registered
    assign bus_req = avs_read_i || avs_write_i;
    assign avs_waitrequest_o = bus_req && !ack_q;
    assign wr_take = avs_write_i && ack_q;
    assign rd_take = avs_read_i && !ack_q;

    // Ack toggles so back-to-back accesses each see a wait cycle
    always_comb begin
        ack_d = bus_req && !ack_q;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= ack_d;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Sampled in the wait cycle; unmapped offsets read zero
    always_comb begin
        rdata_d = rdata_q;
        if (rd_take) begin
            rdata_d = '0;
            case (avs_address_i)
                L2ES_OFS_CTRL: begin
                    rdata_d[L2ES_CTRL_EVT_LSB +: 8] = evt_q;
                    rdata_d[L2ES_CTRL_MASK_LSB +: 8] = mask_q;
                    rdata_d[L2ES_CTRL_EN_BIT] = en_q;
                end
                L2ES_OFS_STATUS: begin
                    rdata_d[L2ES_STAT_SEEN_BIT] = seen_q;
                    rdata_d[L2ES_STAT_MISS_BIT] = miss_seen_q;
                end
                L2ES_OFS_LAST: begin
                    rdata_d[L2ES_LAST_STATE_LSB +: 2] = last_state_q;
                    rdata_d[L2ES_LAST_CLASS_LSB +: 2] = last_class_q;
                    rdata_d[L2ES_LAST_MISS_BIT] = last_miss_q;
                    rdata_d[L2ES_LAST_PF_BIT] = last_pf_q;
                end
                default: begin
                    rdata_d = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign avs_readdata_o = rdata_q;

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    // Byte lanes honoured; a new selection applies from the next request
    always_comb begin
        evt_d = evt_q;
        mask_d = mask_q;
        en_d = en_q;
        if (wr_take && avs_address_i == L2ES_OFS_CTRL) begin
            if (avs_byteenable_i[0]) begin
                evt_d = avs_writedata_i[L2ES_CTRL_EVT_LSB +: 8];
            end
            if (avs_byteenable_i[1]) begin
                mask_d = avs_writedata_i[L2ES_CTRL_MASK_LSB +: 8];
            end
            if (avs_byteenable_i[2]) begin
                en_d = avs_writedata_i[L2ES_CTRL_EN_BIT];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            evt_q <= L2ES_EVT_RST;
            mask_q <= L2ES_MASK_RST;
            en_q <= 1'b0;
        end else begin
            evt_q <= evt_d;
            mask_q <= mask_d;
            en_q <= en_d;
        end
    end

    // ------------------------------------------------------------
    // Request stage
    // ------------------------------------------------------------
    // One register stage cuts the path from the cache pipeline
    always_comb begin
        stg_valid_d = req_valid_i;
        stg_cls_d = l2es_class_e'(req_class_i);
        stg_state_d = l2es_mesi_e'(req_state_i);
        stg_pf_d = req_l2_prefetch_i;
        stg_own_d = req_ownership_i;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            stg_valid_q <= 1'b0;
            stg_cls_q <= L2ES_CL_LOAD;
            stg_state_q <= L2ES_ST_I;
            stg_pf_q <= 1'b0;
            stg_own_q <= 1'b0;
        end else begin
            stg_valid_q <= stg_valid_d;
            stg_cls_q <= stg_cls_d;
            stg_state_q <= stg_state_d;
            stg_pf_q <= stg_pf_d;
            stg_own_q <= stg_own_d;
        end
    end

    // Staged request onto the carrier
    assign stage_if.valid = stg_valid_q;
    assign stage_if.cls = stg_cls_q;
    assign stage_if.state = stg_state_q;
    assign stage_if.l2_pf = stg_pf_q;
    assign stage_if.own = stg_own_q;

    // ------------------------------------------------------------
    // Qualifier and pulse
    // ------------------------------------------------------------
    l2es_match u_match (
        .req (stage_if),
        .event_i (evt_q),
        .umask_i (mask_q),
        .match_o (match),
        .miss_o (miss)
    );

    l2es_pulse u_pulse (
        .clk_i (clk_i),
        .rst_n_i (rst_n_i),
        .enable_i (en_q),
        .match_i (match),
        .miss_i (miss),
        .pulse_o (count_pulse_o),
        .miss_o (count_miss_o)
    );

    assign hit_event = en_q && match;

    // ------------------------------------------------------------
    // Status and last match
    // ------------------------------------------------------------
    // Write one clears; a match in the same cycle wins over the clear
    always_comb begin
        seen_d = seen_q;
        miss_seen_d = miss_seen_q;
        if (wr_take && avs_address_i == L2ES_OFS_STATUS && avs_byteenable_i[0]) begin
            if (avs_writedata_i[L2ES_STAT_SEEN_BIT]) begin
                seen_d = 1'b0;
            end
            if (avs_writedata_i[L2ES_STAT_MISS_BIT]) begin
                miss_seen_d = 1'b0;
            end
        end
        if (hit_event) begin
            seen_d = 1'b1;
        end
        if (hit_event && miss) begin
            miss_seen_d = 1'b1;
        end
    end

    // Snapshot of the most recent counted request
    always_comb begin
        last_state_d = last_state_q;
        last_class_d = last_class_q;
        last_miss_d = last_miss_q;
        last_pf_d = last_pf_q;
        if (hit_event) begin
            last_state_d = stg_state_q;
            last_class_d = stg_cls_q;
            last_miss_d = miss;
            last_pf_d = stg_pf_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            seen_q <= 1'b0;
            miss_seen_q <= 1'b0;
            last_state_q <= 2'h0;
            last_class_q <= 2'h0;
            last_miss_q <= 1'b0;
            last_pf_q <= 1'b0;
        end else begin
            seen_q <= seen_d;
            miss_seen_q <= miss_seen_d;
            last_state_q <= last_state_d;
            last_class_q <= last_class_d;
            last_miss_q <= last_miss_d;
            last_pf_q <= last_pf_d;
        end
    end

endmodule : l2es_top

// ===== sim/l2es_top_asserts.sv
// Checker on the top-level ports of the L2 event selector, with its bind.
`timescale 1ns/1ps
module l2es_top_chk
    import l2es_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Register bus
    input wire logic [L2ES_ADDR_W-1:0] avs_address_i,
    input wire logic avs_write_i,
    input wire logic [L2ES_DATA_W-1:0] avs_writedata_i,
    input wire logic [L2ES_BE_W-1:0] avs_byteenable_i,
    input wire logic avs_waitrequest_o,
    // Request and result
    input wire logic req_valid_i,
    input wire logic [1:0] req_class_i,
    input wire logic [1:0] req_state_i,
    input wire logic req_l2_prefetch_i,
    input wire logic req_ownership_i,
    input wire logic count_pulse_o,
    input wire logic count_miss_o
);
    // ------------------------------------------------------------
    // Shadow of the control register
    // ------------------------------------------------------------
    logic [16:0] ctrl_q;
    logic [16:0] ctrl_d;
    logic [7:0] ev;
    logic [7:0] mk;
    logic go;
    logic lo;
    logic hi;
    // Snooped at the completing edge, so the shadow switches when the design does
    always_comb begin
        ctrl_d = ctrl_q;
        if (avs_write_i && !avs_waitrequest_o && avs_address_i == L2ES_OFS_CTRL) begin
            if (avs_byteenable_i[0]) ctrl_d[7:0] = avs_writedata_i[7:0];
            if (avs_byteenable_i[1]) ctrl_d[15:8] = avs_writedata_i[15:8];
            if (avs_byteenable_i[2]) ctrl_d[16] = avs_writedata_i[16];
        end
    end
    always_ff @(posedge clk_i) begin
        ctrl_q <= rst_n_i ? ctrl_d : 17'h0;
    end
    // Next value: the design qualifies a request with the control of the following cycle
    assign ev = ctrl_d[7:0];
    assign mk = ctrl_d[15:8];
    assign go = req_valid_i && ctrl_d[16];
    assign lo = mk[{1'b0, req_state_i}];
    assign hi = mk[{1'b1, req_state_i}];

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    AST_DATA_DEMAND: assert property (go && ev == 8'h26 && req_class_i == 2'h0 &&
        !req_l2_prefetch_i |-> ##2 count_pulse_o == $past(lo, 2))
        else $error("demand load pulse wrong");
    AST_DATA_PF: assert property (go && ev == 8'h26 && req_class_i == 2'h0 &&
        req_l2_prefetch_i |-> ##2 count_pulse_o == $past(hi, 2))
        else $error("prefetch load pulse wrong");
    AST_DATA_ANY: assert property (go && ev == 8'h26 && mk == 8'hFF && req_class_i == 2'h0
        |-> ##2 count_pulse_o) else $error("any data request not counted");
    AST_PF_SHARED: assert property (go && ev == 8'h26 && req_class_i == 2'h0 && mk[5] &&
        req_l2_prefetch_i && req_state_i == 2'h1 |-> ##2 count_pulse_o &&
        count_miss_o == $past(req_ownership_i, 2)) else $error("shared prefetch miss wrong");
    AST_STORE: assert property (go && ev == 8'h27 && req_class_i == 2'h1
        |-> ##2 count_pulse_o == $past(lo, 2)) else $error("store ownership pulse wrong");
    AST_STORE_HIT: assert property (go && ev == 8'h27 && mk == 8'h0E && req_class_i == 2'h1
        |-> ##2 count_pulse_o == ($past(req_state_i, 2) != 2'h0)) else $error("store hit wrong");
    AST_LOCK: assert property (go && ev == 8'h27 && req_class_i == 2'h2
        |-> ##2 count_pulse_o == $past(hi, 2)) else $error("lock ownership pulse wrong");
    AST_WB: assert property (go && ev == 8'h28 && req_class_i == 2'h3
        |-> ##2 count_pulse_o == $past(lo, 2)) else $error("writeback pulse wrong");
    AST_ONE_PULSE: assert property (count_pulse_o |-> $past(req_valid_i, 2))
        else $error("pulse without request");
    AST_MISS_PAIR: assert property (count_miss_o |-> count_pulse_o)
        else $error("miss without pulse");
    AST_QUIET: assert property (!go |-> ##2 !count_pulse_o)
        else $error("pulse while idle or disabled");

    // Main scenarios reached
    C_MISS: cover property (count_pulse_o && count_miss_o);
    C_PF: cover property (go && ev == 8'h26 && req_l2_prefetch_i ##2 count_pulse_o);
    C_WB: cover property (go && ev == 8'h28 ##2 count_pulse_o);
endmodule : l2es_top_chk

bind l2es_top l2es_top_chk u_l2es_top_chk (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_waitrequest_o(avs_waitrequest_o),
    .req_valid_i(req_valid_i), .req_class_i(req_class_i), .req_state_i(req_state_i),
    .req_l2_prefetch_i(req_l2_prefetch_i), .req_ownership_i(req_ownership_i),
    .count_pulse_o(count_pulse_o), .count_miss_o(count_miss_o)
);

// ===== sim/l2es_pipe_model.sv
// Model of the L2 request pipeline feeding the selector and the counter behind it.
`timescale 1ns/1ps
module l2es_pipe_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Command {class, state, prefetch, ownership}
    input wire logic cmd_valid_i,
    input wire logic [5:0] cmd_i,
    // Toward the selector
    output logic req_valid_o,
    output logic [1:0] req_class_o,
    output logic [1:0] req_state_o,
    output logic req_l2_prefetch_o,
    output logic req_ownership_o,
    // Counter side
    input wire logic count_pulse_i,
    output logic [15:0] count_o
);
    // Idle fields carry the inverted command so stale values never look like a request
    always_ff @(posedge clk_i) begin
        req_valid_o <= rst_n_i && cmd_valid_i;
        if (cmd_valid_i) begin
            {req_class_o, req_state_o, req_l2_prefetch_o, req_ownership_o} <= cmd_i;
        end else begin
            {req_class_o, req_state_o, req_l2_prefetch_o, req_ownership_o} <= ~cmd_i;
        end
        count_o <= rst_n_i ? count_o + {15'h0, count_pulse_i} : 16'h0;
    end
endmodule : l2es_pipe_model

// ===== sim/testbench.sv
// Self-checking bench for the L2 event selector.
`timescale 1ns/1ps
module testbench;
    import l2es_pkg::*;
    logic clk, rst_n, read, write, cmd_valid, req_valid, req_pf, req_own, pulse, miss, wait_req;
    logic [3:0] address, be;
    logic [31:0] wdata, rdata, seed;
    logic [5:0] cmd, last;
    logic [1:0] req_class, req_state;
    logic [1:0] exp_q[$];
    logic [15:0] count;
    logic [7:0] ev, mk;
    logic en, seen, msn, d1, d2;
    int n_fail, checks, cyc, n_exp;
    logic [15:0] cfg[28] = '{16'h2601, 16'h2602, 16'h2604, 16'h2608, 16'h260F, 16'h2610,
        16'h2620, 16'h2640, 16'h2680, 16'h26F0, 16'h26FF, 16'h2701, 16'h2702, 16'h2708,
        16'h270E, 16'h270F, 16'h2710, 16'h2720, 16'h2740, 16'h2780, 16'h27E0, 16'h27F0,
        16'h2801, 16'h2802, 16'h2804, 16'h2808, 16'h280F, 16'h00FF};

    l2es_top u_l2es_top (.clk_i(clk), .rst_n_i(rst_n), .avs_address_i(address),
        .avs_read_i(read), .avs_write_i(write), .avs_writedata_i(wdata),
        .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_req),
        .req_valid_i(req_valid), .req_class_i(req_class), .req_state_i(req_state),
        .req_l2_prefetch_i(req_pf), .req_ownership_i(req_own), .count_pulse_o(pulse),
        .count_miss_o(miss));
    l2es_pipe_model u_l2es_pipe_model (.clk_i(clk), .rst_n_i(rst_n), .cmd_valid_i(cmd_valid),
        .cmd_i(cmd), .req_valid_o(req_valid), .req_class_o(req_class), .req_state_o(req_state),
        .req_l2_prefetch_o(req_pf), .req_ownership_o(req_own), .count_pulse_i(pulse),
        .count_o(count));

    // ------------------------------------------------------------
    // Compare, verdict and bus tasks
    // ------------------------------------------------------------
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : check
    task automatic check_res(input logic [1:0] e, input logic [1:0] g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected pulse_miss expected %b seen %b at %0t", e, g, $time);
        end
    endtask : check_res
    task automatic print_verdict();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : print_verdict
    // Request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        address <= a;
        wdata <= d;
        write <= wr;
        read <= !wr;
        do @(posedge clk); while (wait_req !== 1'b0);
        write <= 1'b0;
        read <= 1'b0;
    endtask : bus
    task automatic rd(input string nm, input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        check(nm, e, rdata);
    endtask : rd

    // ------------------------------------------------------------
    // Request driver with expectation notes
    // ------------------------------------------------------------
    function automatic logic [1:0] expect_res(input logic [5:0] c);
        logic hit;
        case (ev)
            8'h26: hit = c[5:4] == 2'h0 && mk[{c[1], c[3:2]}];
            8'h27: hit = (c[5:4] == 2'h1 && mk[{1'b0, c[3:2]}]) ||
                (c[5:4] == 2'h2 && mk[{1'b1, c[3:2]}]);
            8'h28: hit = c[5:4] == 2'h3 && mk[{1'b0, c[3:2]}];
            default: hit = 1'b0;
        endcase
        hit = hit && en;
        return {hit, hit && (c[3:2] == 2'h0 || (c[1] && c[0] && c[3:2] == 2'h1))};
    endfunction : expect_res
    task automatic send(input logic v, input logic [5:0] c);
        logic [1:0] e;
        @(posedge clk);
        cmd_valid <= v;
        cmd <= c;
        e = expect_res(c);
        if (v) exp_q.push_back(e);
        if (v && e[1]) begin
            n_exp++;
            seen = 1'b1;
            msn = msn | e[0];
            last = {c[1], e[0], c[5:4], c[3:2]};
        end
    endtask : send
    // Random back-to-back traffic; prefetch flag only on loads
    task automatic traffic(input int n);
        logic [31:0] r;
        for (int i = 0; i < n; i++) begin
            r = $random(seed);
            send(r[7:6] != 2'h0, {r[5:2], r[1] && r[5:4] == 2'h0, r[0]});
        end
        send(1'b0, 6'h00);
        repeat (4) @(posedge clk);
    endtask : traffic

    // Clock, timeout and result watcher
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        d1 <= rst_n && req_valid;
        d2 <= d1;
        if (cyc == 20000) begin
            n_fail++;
            print_verdict();
        end
    end
    // Settled outputs sampled mid-cycle, two cycles after each request
    always @(negedge clk) begin
        if (rst_n && d2) check_res(exp_q.pop_front(), {pulse, miss});
        else if (rst_n) check_res(2'h0, {pulse, miss});
    end

    // Main sequence
    initial begin
        {rst_n, read, write, cmd_valid, seen, msn, en} = 7'h0;
        {address, wdata, cmd, ev, mk, last} = '0;
        be = 4'hF;
        seed = 32'h2862;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rd("ctrl", L2ES_OFS_CTRL, 32'h0);
        rd("status", L2ES_OFS_STATUS, 32'h0);
        rd("last", L2ES_OFS_LAST, 32'h0);
        rd("unmapped", 4'hC, 32'h0);
        {ev, mk} = 16'h26FF;
        bus(1'b1, L2ES_OFS_CTRL, 32'h0000FF26);
        traffic(30);
        foreach (cfg[i]) begin
            {ev, mk} = cfg[i];
            en = 1'b1;
            bus(1'b1, L2ES_OFS_CTRL, {15'h0, 1'b1, mk, ev});
            rd("ctrl", L2ES_OFS_CTRL, {15'h0, 1'b1, mk, ev});
            traffic(30);
        end
        rd("status", L2ES_OFS_STATUS, {30'h0, msn, seen});
        bus(1'b1, L2ES_OFS_STATUS, 32'h3);
        {seen, msn} = 2'h0;
        rd("status", L2ES_OFS_STATUS, 32'h0);
        {ev, mk} = 16'h2620;
        bus(1'b1, L2ES_OFS_CTRL, 32'h00012026);
        send(1'b1, 6'h07);
        send(1'b1, 6'h06);
        traffic(0);
        rd("last", L2ES_OFS_LAST, {26'h0, last});
        bus(1'b1, L2ES_OFS_LAST, 32'hFFFFFFFF);
        rd("last", L2ES_OFS_LAST, {26'h0, last});
        rd("status", L2ES_OFS_STATUS, {30'h0, msn, seen});
        be <= 4'h2;
        bus(1'b1, L2ES_OFS_CTRL, 32'h00000F27);
        be <= 4'hF;
        rd("ctrl", L2ES_OFS_CTRL, 32'h00010F26);
        check("count", {16'h0, n_exp[15:0]}, {16'h0, count});
        print_verdict();
    end
endmodule : testbench
